// >>> hw/dac_access_ctrl.v
// D-channel access control: stop/go generation, echo ones counting, collision detection
`timescale 1ns/1ns
`include "dac_consts.vh"

module dac_access_ctrl (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [1:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       link_clk_pin,
  input  wire       frame_sync_pin,
  input  wire       bus_up_pin,
  output reg        bus_down_out,
  output reg        bus_down_oe,
  input  wire       line_bit_valid,
  input  wire       line_tx_d,
  input  wire       line_echo,
  input  wire       line_tx_busy,
  input  wire       line_frame_done,
  input  wire       ci_valid,
  input  wire [3:0] ci_cmd,
  output reg        stopgo,
  output reg        collision,
  output reg        maint_pin5_out,
  output reg        maint_pin5_oe
);

  // ==========================================================
  // Priority threshold lookup
  function [3:0] dac_threshold;
    input class2;
    input lower;
    begin
      case ({class2, lower})
        2'b00: begin
          dac_threshold = `DAC_ONES_C1_NORMAL;
        end
        2'b01: begin
          dac_threshold = `DAC_ONES_C1_LOWER;
        end
        2'b10: begin
          dac_threshold = `DAC_ONES_C2_NORMAL;
        end
        default: begin
          dac_threshold = `DAC_ONES_C2_LOWER;
        end
      endcase
    end
  endfunction

  // ==========================================================
  // Registers and state
  reg        sge_reg;
  reg        te_en_reg;
  reg        class2_reg;
  reg        lower_reg;
  reg [3:0]  ones_reg;
  reg [3:0]  ones_next;
  reg        stopgo_next;
  reg        lower_next;
  reg        coll_next;
  reg        coll_seen_reg;
  reg        link_s1;
  reg        link_s2;
  reg        link_s3;
  reg        fsync_s1;
  reg        fsync_s2;
  reg        fsync_s3;
  reg        up_s1;
  reg        up_s2;
  reg [7:0]  half_cnt_reg;
  reg        bac_reg;
  reg [2:0]  tba_reg;
  reg        bac_work;
  reg [2:0]  tba_work;
  reg        frame_seen_reg;

  wire       link_rise;
  wire       link_fall;
  wire       frame_start;
  wire [6:0] bit_idx;
  wire [6:0] next_bit_idx;
  wire [7:0] half_cnt_inc;
  wire [3:0] thresh;

  assign link_rise    = link_s2 & ~link_s3;
  assign link_fall    = ~link_s2 & link_s3;
  assign frame_start  = fsync_s2 & ~fsync_s3;
  assign half_cnt_inc = half_cnt_reg + 8'h01;
  assign bit_idx      = half_cnt_reg[7:1];
  assign next_bit_idx = half_cnt_inc[7:1];
  assign thresh       = dac_threshold(class2_reg, lower_reg);

  // ==========================================================
  // Pin synchronisers; the third stage feeds only edge detection
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_s1  <= 1'b0;
      link_s2  <= 1'b0;
      link_s3  <= 1'b0;
      fsync_s1 <= 1'b0;
      fsync_s2 <= 1'b0;
      fsync_s3 <= 1'b0;
      up_s1    <= 1'b1;
      up_s2    <= 1'b1;
    end else begin
      link_s1  <= link_clk_pin;
      link_s2  <= link_s1;
      link_s3  <= link_s2;
      fsync_s1 <= frame_sync_pin;
      fsync_s2 <= fsync_s1;
      fsync_s3 <= fsync_s2;
      up_s1    <= bus_up_pin;
      up_s2    <= up_s1;
    end
  end

  // ==========================================================
  // Terminal bus bit timing: two link clock periods per bit
  // Reset alone does not align the count; the first frame sync does
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_reg <= 8'h00;
    end else if (frame_start) begin
      half_cnt_reg <= 8'h00;
    end else if (link_rise) begin
      half_cnt_reg <= half_cnt_inc;
    end
  end

  // ==========================================================
  // Downstream stop/go slot, driven only during its own bit
  // Outside the slot the line is released so other sources can drive
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_down_out <= 1'b1;
      bus_down_oe  <= 1'b0;
    end else if (frame_start) begin
      bus_down_out <= 1'b1;
      bus_down_oe  <= 1'b0;
    end else if (link_rise) begin
      if (next_bit_idx == `DAC_SG_POS && te_en_reg) begin
        bus_down_out <= stopgo;
        bus_down_oe  <= 1'b1;
      end else begin
        bus_down_out <= 1'b1;
        bus_down_oe  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Upstream grant flag and arbitration address snapshot.
  // The wire already resolves zeros over ones, so the value read
  // back is the address of the winning contender.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bac_work       <= 1'b1;
      tba_work       <= 3'h7;
      bac_reg        <= 1'b1;
      tba_reg        <= 3'h7;
      frame_seen_reg <= 1'b0;
    end else if (frame_start) begin
      bac_reg        <= bac_work;
      tba_reg        <= tba_work;
      frame_seen_reg <= 1'b1;
      bac_work       <= 1'b1;
      tba_work       <= 3'h7;
    end else if (link_fall && half_cnt_reg[0]) begin
      case (bit_idx)
        `DAC_BAC_POS: begin
          bac_work <= up_s2;
        end
        `DAC_TBA0_POS: begin
          tba_work[0] <= up_s2;
        end
        `DAC_TBA1_POS: begin
          tba_work[1] <= up_s2;
        end
        `DAC_TBA2_POS: begin
          tba_work[2] <= up_s2;
        end
        default: begin
          bac_work <= bac_work;
        end
      endcase
    end
  end

  // ==========================================================
  // Echo ones counter, collision check and stop/go decision
  always @* begin
    ones_next   = ones_reg;
    stopgo_next = stopgo;
    lower_next  = lower_reg;
    coll_next   = 1'b0;
    // Terminal mode off holds stop so no controller sends blindly
    if (!te_en_reg) begin
      ones_next   = 4'h0;
      stopgo_next = 1'b1;
    end else if (line_frame_done) begin
      ones_next   = 4'h0;
      stopgo_next = 1'b1;
      lower_next  = 1'b1;
    end else if (line_bit_valid) begin
      if (line_tx_d != line_echo) begin
        coll_next   = 1'b1;
        ones_next   = 4'h0;
        stopgo_next = 1'b1;
      end else if (!line_echo) begin
        ones_next = 4'h0;
        // A zero of our own frame restarts the count but keeps go
        if (!line_tx_busy) begin
          stopgo_next = 1'b1;
        end
      end else begin
        if (ones_reg != `DAC_ONES_MAX) begin
          ones_next = ones_reg + 4'h1;
        end
        if (!line_tx_busy && ones_next >= thresh) begin
          stopgo_next = 1'b0;
        end
        // Lower level is left once a full lower-level count of
        // ones shows every other terminal had its turn
        if (lower_reg && ones_next >= dac_threshold(class2_reg, 1'b1)) begin
          lower_next = 1'b0;
        end
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ones_reg   <= 4'h0;
      stopgo     <= 1'b1;
      lower_reg  <= 1'b0;
      collision  <= 1'b0;
      class2_reg <= 1'b0;
    end else begin
      ones_reg  <= ones_next;
      stopgo    <= stopgo_next;
      lower_reg <= lower_next;
      collision <= coll_next;
      if (ci_valid && ci_cmd == `DAC_CI_AR_CLASS1) begin
        class2_reg <= 1'b0;
      end else if (ci_valid && ci_cmd == `DAC_CI_AR_CLASS2) begin
        class2_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Maintenance pin five mirrors stop/go when enabled
  // Fed from the next value so the pin changes with stop/go itself
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maint_pin5_out <= 1'b1;
      maint_pin5_oe  <= 1'b0;
    end else begin
      maint_pin5_out <= sge_reg ? stopgo_next : 1'b1;
      maint_pin5_oe  <= sge_reg;
    end
  end

  // ==========================================================
  // Register port; collision flag is sticky, set wins over clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sge_reg       <= 1'b0;
      te_en_reg     <= 1'b1;
      coll_seen_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `DAC_ADDR_CTRL) begin
        sge_reg   <= reg_wdata[`DAC_CTRL_SGE_BIT];
        te_en_reg <= reg_wdata[`DAC_CTRL_TE_BIT];
      end
      if (coll_next) begin
        coll_seen_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `DAC_ADDR_STATUS
                   && reg_wdata[`DAC_ST_COLL_BIT]) begin
        coll_seen_reg <= 1'b0;
      end
    end
  end

  // Read data is zero outside the answer cycle, so a stray sample is harmless
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `DAC_ADDR_CTRL: begin
          reg_rdata <= {6'h00, te_en_reg, sge_reg};
        end
        `DAC_ADDR_STATUS: begin
          reg_rdata <= {ones_reg, coll_seen_reg, lower_reg,
                        class2_reg, stopgo};
        end
        `DAC_ADDR_ARB: begin
          reg_rdata <= {3'h0, frame_seen_reg, tba_reg, bac_reg};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // dac_access_ctrl

// >>> hw/dac_consts.vh
// Constants for the D-channel access control block
`ifndef DAC_CONSTS_VH
`define DAC_CONSTS_VH

// ==========================================================
// Register map (plain register port, 2-bit address)
`define DAC_ADDR_CTRL       2'h0
`define DAC_ADDR_STATUS     2'h1
`define DAC_ADDR_ARB        2'h2

// ==========================================================
// Control register fields
`define DAC_CTRL_SGE_BIT    0
`define DAC_CTRL_TE_BIT     1
`define DAC_CTRL_RESET      8'h02

// ==========================================================
// Status register fields
`define DAC_ST_SG_BIT       0
`define DAC_ST_CLASS_BIT    1
`define DAC_ST_LOWER_BIT    2
`define DAC_ST_COLL_BIT     3
`define DAC_ST_CNT_LSB      4

// ==========================================================
// Arbitration snapshot register fields
`define DAC_ARB_BAC_BIT     0
`define DAC_ARB_TBA_LSB     1
`define DAC_ARB_BUSY_BIT    4

// ==========================================================
// Terminal bus frame layout, bit positions from frame start
`define DAC_BAC_POS         7'd90
`define DAC_TBA0_POS        7'd91
`define DAC_TBA1_POS        7'd92
`define DAC_TBA2_POS        7'd93
`define DAC_SG_POS          7'd90

// ==========================================================
// Consecutive echo ones required before go
`define DAC_ONES_C1_NORMAL  4'd8
`define DAC_ONES_C2_NORMAL  4'd10
`define DAC_ONES_C1_LOWER   4'd9
`define DAC_ONES_C2_LOWER   4'd11
`define DAC_ONES_MAX        4'hf

// ==========================================================
// Command/indication codes
`define DAC_CI_AR_CLASS1    4'h8
`define DAC_CI_AR_CLASS2    4'h9

`endif

// >>> test/dac_access_ctrl_chk.sv
// Assertion checker for the D-channel access control block
`timescale 1ns/1ns
module dac_access_ctrl_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       line_bit_valid,
  input wire logic       line_tx_d,
  input wire logic       line_echo,
  input wire logic       line_tx_busy,
  input wire logic       line_frame_done,
  input wire logic       bus_down_oe,
  input wire logic       stopgo,
  input wire logic       collision,
  input wire logic       maint_pin5_out,
  input wire logic       maint_pin5_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Decoded line events
  wire mis   = line_bit_valid && !line_frame_done && (line_tx_d != line_echo);
  wire idle0 = line_bit_valid && !line_frame_done && !line_echo && !line_tx_d && !line_tx_busy;
  sequence s_stop_pulse;
    stopgo && collision;
  endsequence
  a_mismatch_stop: assert property (mis |=> s_stop_pulse)
    else $error("mismatch did not stop");
  a_collision_cause: assert property (!mis |=> !collision)
    else $error("collision without mismatch");
  a_done_stop: assert property (line_frame_done |=> stopgo)
    else $error("frame end did not stop");
  a_zero_idle: assert property (idle0 |=> stopgo)
    else $error("zero echo did not stop");
  a_go_after_one: assert property ($fell(stopgo) |-> $past(line_bit_valid) && $past(line_echo))
    else $error("go without echo one");
  a_pin5_copy: assert property (maint_pin5_oe |-> maint_pin5_out == stopgo)
    else $error("pin five differs from stop/go");
  a_pin5_idle: assert property (!maint_pin5_oe |-> maint_pin5_out)
    else $error("pin five low while disabled");
  a_down_slot: assert property ($rose(bus_down_oe) |-> ##[1:20] !bus_down_oe)
    else $error("downstream drive too long");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_reset_stop: assert property ($rose(rst_n) |-> stopgo)
    else $error("go right after reset");
endmodule // dac_access_ctrl_chk
bind dac_access_ctrl dac_access_ctrl_chk dac_access_ctrl_chk_inst (.clk(clk), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_bit_valid(line_bit_valid),
  .line_tx_d(line_tx_d), .line_echo(line_echo), .line_tx_busy(line_tx_busy),
  .line_frame_done(line_frame_done), .bus_down_oe(bus_down_oe), .stopgo(stopgo),
  .collision(collision), .maint_pin5_out(maint_pin5_out), .maint_pin5_oe(maint_pin5_oe));

// >>> test/dac_access_ctrl_tb.sv
// Self-checking testbench for the D-channel access control block
`timescale 1ns/1ns
`include "dac_consts.vh"
module dac_access_ctrl_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       link_clk = 1'b0;
  logic       frame_sync = 1'b0;
  logic       v = 1'b0;
  logic       tx = 1'b0;
  logic       echo = 1'b0;
  logic       busy = 1'b0;
  logic       done = 1'b0;
  logic       ci_valid = 1'b0;
  logic [3:0] ci_cmd = 4'h0;
  logic       want = 1'b0;
  logic [7:0] lpos = 8'h00;
  logic [7:0] rdata;
  logic [3:0] n;
  wire  [7:0] reg_rdata;
  wire        drv_a, drv_b, stopgo, collision;
  wire        bus_up = drv_a & drv_b;
  int         failures = 0;
  int         n_checks = 0;
  int         cycles = 0;
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #200 link_clk = ~link_clk;
  end
  always @(posedge link_clk) lpos <= frame_sync ? 8'h00 : lpos + 8'h01;
  always @(negedge link_clk) frame_sync <= (lpos == 8'd191);
  dac_access_ctrl dac_access_ctrl_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_clk_pin(link_clk), .frame_sync_pin(frame_sync), .bus_up_pin(bus_up),
    .bus_down_out(), .bus_down_oe(), .line_bit_valid(v), .line_tx_d(tx), .line_echo(echo),
    .line_tx_busy(busy), .line_frame_done(done), .ci_valid(ci_valid), .ci_cmd(ci_cmd),
    .stopgo(stopgo), .collision(collision), .maint_pin5_out(), .maint_pin5_oe());
  dac_tic_ctrl #(.ADDR(3'h5)) dac_tic_ctrl_inst (.link_clk(link_clk), .frame_sync(frame_sync),
    .want(want), .line(bus_up), .drv(drv_a));
  dac_tic_ctrl #(.ADDR(3'h6)) dac_tic_ctrl_b_inst (.link_clk(link_clk),
    .frame_sync(frame_sync), .want(want), .line(bus_up), .drv(drv_b));
  // ==========================================================
  // Expectations
  function automatic logic [3:0] need(input int c2, input int lo);
    need = c2 ? (lo ? `DAC_ONES_C2_LOWER : `DAC_ONES_C2_NORMAL)
              : (lo ? `DAC_ONES_C1_LOWER : `DAC_ONES_C1_NORMAL);
  endfunction
  // Resolved wired-AND address; a party drops out once its bit is overwritten
  function automatic logic [2:0] win(input logic [2:0] a, input logic [2:0] b);
    logic al, bl, l;
    al = 1'b1;
    bl = 1'b1;
    for (int i = 0; i < 3; i++) begin
      l = (al ? a[i] : 1'b1) & (bl ? b[i] : 1'b1);
      al = al && a[i] == l;
      bl = bl && b[i] == l;
      win[i] = l;
    end
  endfunction
  // ==========================================================
  // Drivers and reporting
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdata = reg_rdata;
  endtask
  task automatic ci(input logic [3:0] c);
    ci_valid <= 1'b1;
    ci_cmd <= c;
    @(posedge clk);
    ci_valid <= 1'b0;
    #1;
  endtask
  task automatic bitp(input logic t, input logic e, input logic b, input logic d);
    v <= !d;
    done <= d;
    tx <= t;
    echo <= e;
    busy <= b;
    @(posedge clk);
    v <= 1'b0;
    done <= 1'b0;
    #1;
  endtask
  task automatic next_frame;
    @(posedge frame_sync);
    repeat (40) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      give_verdict;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(91835));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`DAC_ADDR_CTRL);
    chk(rdata, `DAC_CTRL_RESET);
    wr(2'h3, 8'hff);
    rd(2'h3);
    chk(rdata, 8'h00);
    wr(`DAC_ADDR_CTRL, 8'h03);
    for (int c = 0; c < 2; c++) begin
      ci(c ? `DAC_CI_AR_CLASS2 : `DAC_CI_AR_CLASS1);
      ci(4'hc);
      rd(`DAC_ADDR_STATUS);
      chk(rdata[`DAC_ST_CLASS_BIT], c);
      for (int lo = 0; lo < 2; lo++) begin
        n = need(c, lo);
        bitp(1'b0, 1'b0, 1'b0, 1'b0);
        chk(stopgo, 1'b1);
        repeat ($urandom_range(n - 1, 1)) bitp(1'b1, 1'b1, 1'b0, 1'b0);
        bitp(1'b0, 1'b0, 1'b1, 1'b0);
        repeat (n - 1) bitp(1'b1, 1'b1, 1'b0, 1'b0);
        chk(stopgo, 1'b1);
        bitp(1'b1, 1'b1, 1'b0, 1'b0);
        chk(stopgo, 1'b0);
        if (lo == 0) begin
          bitp(1'b1, 1'b1, 1'b0, 1'b1);
          chk(stopgo, 1'b1);
          rd(`DAC_ADDR_STATUS);
          chk(rdata[`DAC_ST_LOWER_BIT], 1'b1);
        end
      end
      bitp(1'b0, 1'b1, 1'b1, 1'b0);
      chk({collision, stopgo}, 2'h3);
    end
    rd(`DAC_ADDR_STATUS);
    chk(rdata[`DAC_ST_COLL_BIT], 1'b1);
    wr(`DAC_ADDR_STATUS, 8'h08);
    rd(`DAC_ADDR_STATUS);
    chk(rdata[`DAC_ST_COLL_BIT], 1'b0);
    wr(`DAC_ADDR_CTRL, 8'h01);
    repeat (12) bitp(1'b1, 1'b1, 1'b0, 1'b0);
    chk(stopgo, 1'b1);
    rd(`DAC_ADDR_STATUS);
    chk(rdata[7:4], 4'h0);
    wr(`DAC_ADDR_CTRL, 8'h03);
    // Start contending early in a frame so arbitration falls in that frame
    next_frame();
    want <= 1'b1;
    next_frame();
    rd(`DAC_ADDR_ARB);
    chk(rdata, {3'h0, 1'b1, win(3'h5, 3'h6), 1'b1});
    next_frame();
    rd(`DAC_ADDR_ARB);
    chk(rdata, {3'h0, 1'b1, win(3'h5, 3'h6), 1'b0});
    want <= 1'b0;
    next_frame();
    next_frame();
    rd(`DAC_ADDR_ARB);
    chk(rdata, 8'h1f);
    give_verdict;
  end
endmodule // dac_access_ctrl_tb

// >>> test/dac_tic_ctrl.sv
// Behavioural HDLC controller contending for the shared access bus timeslot
`timescale 1ns/1ns
module dac_tic_ctrl #(
  parameter logic [2:0] ADDR = 3'h7
) (
  input  wire logic link_clk,
  input  wire logic frame_sync,
  input  wire logic want,
  input  wire logic line,
  output logic      drv
);
  logic [7:0] pos = 8'h00;
  logic       contend = 1'b0;
  logic       won = 1'b0;
  logic       rest = 1'b0;
  wire  [6:0] bit_n = pos[7:1];
  always @(posedge link_clk) pos <= frame_sync ? 8'h00 : pos + 8'h01;
  // Ones are released so that zeros of other parties win
  always_comb begin
    drv = 1'b1;
    if (bit_n == 7'd90) drv = !won;
    else if (bit_n >= 7'd91 && bit_n <= 7'd93 && contend) drv = ADDR[bit_n - 7'd91];
  end
  // Read back in the second half; release only at bit 95 so no sampled slot changes late
  always @(negedge link_clk) if (pos[0]) begin
    if (bit_n == 7'd90 && !won) begin
      contend <= want && line && !rest;
      rest <= 1'b0;
    end else if (bit_n >= 7'd91 && bit_n <= 7'd93 && contend && line != ADDR[bit_n - 7'd91])
      contend <= 1'b0;
    else if (bit_n == 7'd94) won <= contend;
    else if (bit_n == 7'd95 && won && !want) begin
      won <= 1'b0;
      contend <= 1'b0;
      rest <= 1'b1;
    end
  end
endmodule // dac_tic_ctrl
